// file: logic/incr_alu.sv
// Increment datapath: sum and arithmetic flags
`include "incr_defs.svh"
module incr_alu
  import incr_pkg::*;
#(
  parameter int unsigned DW = 8
) (
  // Operand
  input  wire logic [DW-1:0]         operand_i,
  // Result and flags
  output logic      [DW-1:0]         result_o,
  output logic      [`FLG_WIDTH-1:0] flags_o
);
  import incr_pkg::*;

  if (DW != 8) begin : g_bad_width
    $error("incr_alu serves an 8-bit operand only");
  end

  always_comb begin
    result_o = operand_i + DW'(1);
    flags_o = '0;
    flags_o[`FLG_CARRY]         = &operand_i;
    flags_o[`FLG_HALF_CARRY]    = &operand_i[3:0];
    flags_o[`FLG_ZERO]          = (result_o == '0);
    flags_o[`FLG_SIGNED_EXCESS] = (operand_i == {1'b0, {(DW-1){1'b1}}});
    flags_o[`FLG_NEGATIVE]      = result_o[DW-1];
  end
endmodule

// file: logic/incr_defs.svh
// Offsets, field positions, reset values and timing counts of the increment core
`ifndef INCR_DEFS_SVH
`define INCR_DEFS_SVH

// Register byte addresses on the APB
`define REG_ARITH_FLAGS        14'h3FD8
`define REG_BANK_POINTER       14'h3FE0
`define REG_WORKING_ACC        14'h3FE8
`define REG_CORE_CTRL          14'h0000
`define REG_CORE_STATE         14'h0004

// Flag positions inside arith_flags
`define FLG_CARRY              0
`define FLG_HALF_CARRY         1
`define FLG_ZERO               2
`define FLG_SIGNED_EXCESS      3
`define FLG_NEGATIVE           4
`define FLG_WIDTH              5

// Control register fields
`define CTRL_EXT_SET_EN        0

// Reset values
`define RST_ARITH_FLAGS        5'h00
`define RST_BANK_POINTER       8'h00
`define RST_WORKING_ACC        8'h00
`define RST_EXT_SET_EN         1'b0

// Instruction fields
`define OPC_HI                 15
`define OPC_LO                 10
`define OPC_ADD_ONE            6'h0A
`define OPC_ADD_ONE_SKIP       6'h0F
`define DEST_BIT               9
`define BANK_BIT               8

// Addressing
`define DMEM_AW                14
`define INDEXED_LIMIT          8'h5F
`define ACCESS_LOW_PAGE        6'h00
`define ACCESS_HIGH_PAGE       6'h3F

// Last phase count of an instruction cycle (four phases, counted 0 to 3)
`define PHASES_PER_CYCLE       2'h3

`endif

// file: logic/incr_exec.sv
// Execution core for the two increment instructions with APB registers
// Notes on behaviour
// - Destination bit picks accumulator or register
// - Plain form sets flags; skip form none
// - Bank bit: access bank or bank pointer
// - Extended set, low address: indexed offset
// - Zero result skips prefetched instruction
// - Two-word follower makes three cycles
// - One word, decode/read/process/write phases
// - Opcodes 001010 and 001111, then d,a,f
//
// Added by the designer: the APB interface to the registers.
`include "incr_defs.svh"
module incr_exec
  import incr_pkg::*;
#(
  parameter int unsigned DMEM_AW = `DMEM_AW
) (
  // Clock, reset, enable
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               ce_i,
  // Instruction fetch
  input  wire logic               instr_valid_i,
  input  wire logic [15:0]        instr_word_i,
  input  wire logic               next_two_word_i,
  output logic                    busy_o,
  output logic                    done_o,
  output logic                    skip_o,
  // Indexed literal offset base
  input  wire logic [DMEM_AW-1:0] index_base_i,
  // Data memory
  output logic      [DMEM_AW-1:0] dmem_addr_o,
  output logic                    dmem_rd_o,
  input  wire logic [7:0]         dmem_rdata_i,
  output logic                    dmem_wr_o,
  output logic      [7:0]         dmem_wdata_o,
  // APB slave
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [DMEM_AW-1:0] paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic                    pready_o,
  output logic      [31:0]        prdata_o,
  output logic                    pslverr_o
);
  import incr_pkg::*;

  if (DMEM_AW != `DMEM_AW) begin : g_bad_aw
    $error("incr_exec serves a 14-bit data address only");
  end

  logic [1:0]          rst_sync_q;
  logic                rst_n;
  core_state_t         q;
  core_state_t         d;
  logic [7:0]          alu_res;
  logic [`FLG_WIDTH-1:0] alu_flg;

  // Reset is released through two flops so its removal is clock aligned
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  incr_alu #(
    .DW        (8)
  ) u_alu (
    .operand_i (dmem_rdata_i),
    .result_o  (alu_res),
    .flags_o   (alu_flg)
  );

  always_comb begin
    logic [7:0]  f;
    logic        is_inc;
    logic        is_skip;
    logic        mapped;
    logic [31:0] rdata;
    f       = q.ir[7:0];
    is_inc  = 1'b0;
    is_skip = 1'b0;
    mapped  = 1'b0;
    rdata   = '0;
    d       = q;
    d.done  = 1'b0;
    d.mrd   = 1'b0;
    d.mwr   = 1'b0;

    is_inc  = (q.ir[`OPC_HI:`OPC_LO] == `OPC_ADD_ONE);
    is_skip = (q.ir[`OPC_HI:`OPC_LO] == `OPC_ADD_ONE_SKIP);

    // APB slave: answer is prepared in setup, taken in access
    unique case (paddr_i)
      `REG_ARITH_FLAGS: begin
        mapped = 1'b1;
        rdata  = {27'h0, q.flags};
      end
      `REG_BANK_POINTER: begin
        mapped = 1'b1;
        rdata  = {24'h0, q.bank_pointer};
      end
      `REG_WORKING_ACC: begin
        mapped = 1'b1;
        rdata  = {24'h0, q.working_accumulator};
      end
      `REG_CORE_CTRL: begin
        mapped = 1'b1;
        rdata  = {31'h0, q.ext_en};
      end
      `REG_CORE_STATE: begin
        mapped = 1'b1;
        rdata  = {25'h0, q.skip, q.nop_left, q.st != ST_IDLE,
                  3'(q.st)};
      end
      default: begin
        mapped = 1'b0;
        rdata  = '0;
      end
    endcase

    if (psel_i && !penable_i && !q.pready) begin
      d.pready  = 1'b1;
      d.pslverr = !mapped;
      d.prdata  = pwrite_i ? 32'h0000_0000 : rdata;
    end else if (psel_i && penable_i && q.pready) begin
      d.pready  = 1'b0;
      d.pslverr = 1'b0;
      d.prdata  = '0;
      if (pwrite_i) begin
        unique case (paddr_i)
          `REG_ARITH_FLAGS:  d.flags  = pwdata_i[`FLG_WIDTH-1:0];
          `REG_BANK_POINTER: d.bank_pointer    = pwdata_i[7:0];
          `REG_WORKING_ACC:  d.working_accumulator   = pwdata_i[7:0];
          `REG_CORE_CTRL:    d.ext_en = pwdata_i[`CTRL_EXT_SET_EN];
          default: ;
        endcase
      end
    end

    // Core sequence; a core write in the same edge overrides the APB one
    unique case (q.st)
      ST_IDLE: begin
        if (instr_valid_i) begin
          d.ir       = instr_word_i;
          d.next_two = next_two_word_i;
          d.skip     = 1'b0;
          d.st       = ST_DECODE;
        end
      end
      ST_DECODE: begin
        if (!is_inc && !is_skip) begin
          d.st = ST_IDLE;
        end else begin
          d.mrd = 1'b1;
          d.st  = ST_READ;
          if (q.ir[`BANK_BIT]) begin
            d.maddr = {q.bank_pointer[5:0], f};
          end else if (q.ext_en && f <= `INDEXED_LIMIT) begin
            d.maddr = index_base_i + {6'h00, f};
          end else if (f <= `INDEXED_LIMIT) begin
            d.maddr = {`ACCESS_LOW_PAGE, f};
          end else begin
            d.maddr = {`ACCESS_HIGH_PAGE, f};
          end
        end
      end
      ST_READ: begin
        d.res     = alu_res;
        d.flg_new = alu_flg;
        d.st      = ST_PROCESS;
      end
      ST_PROCESS: begin
        d.st = ST_WRITE;
        if (q.ir[`DEST_BIT]) begin
          d.mwr    = 1'b1;
          d.mwdata = q.res;
        end else begin
          d.working_accumulator = q.res;
        end
        if (is_inc) begin
          d.flags = q.flg_new;
        end
        if (is_skip && q.res == 8'h00) begin
          d.skip = 1'b1;
          d.nop_left = q.next_two ? 2'h2 : 2'h1;
        end else begin
          d.nop_left = 2'h0;
        end
      end
      ST_WRITE: begin
        d.nop_ph = 2'h0;
        if (q.nop_left != 2'h0) begin
          d.st = ST_NOP;
        end else begin
          d.st   = ST_IDLE;
          d.done = 1'b1;
        end
      end
      ST_NOP: begin
        d.nop_ph = q.nop_ph + 2'h1;
        if (q.nop_ph == `PHASES_PER_CYCLE) begin
          d.nop_left = q.nop_left - 2'h1;
          if (q.nop_left == 2'h1) begin
            d.st   = ST_IDLE;
            d.done = 1'b1;
          end
        end
      end
      default: d.st = ST_IDLE;
    endcase
    // Busy is registered so the port comes straight from a flop
    d.busy = (d.st != ST_IDLE);
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q          <= '0;
      q.st       <= ST_IDLE;
      q.flags    <= `RST_ARITH_FLAGS;
      q.bank_pointer      <= `RST_BANK_POINTER;
      q.working_accumulator     <= `RST_WORKING_ACC;
      q.ext_en   <= `RST_EXT_SET_EN;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // Outputs straight from the state flops
  assign busy_o       = q.busy;
  assign done_o       = q.done;
  assign skip_o       = q.skip;
  assign dmem_addr_o  = q.maddr;
  assign dmem_rd_o    = q.mrd;
  assign dmem_wr_o    = q.mwr;
  assign dmem_wdata_o = q.mwdata;
  assign pready_o     = q.pready;
  assign prdata_o     = q.prdata;
  assign pslverr_o    = q.pslverr;
endmodule

// file: logic/incr_pkg.sv
// Types of the increment core
package incr_pkg;
  `include "incr_defs.svh"

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DECODE,
    ST_READ,
    ST_PROCESS,
    ST_WRITE,
    ST_NOP
  } phase_t;

  typedef struct packed {
    phase_t                    st;
    logic [1:0]                nop_ph;
    logic [1:0]                nop_left;
    logic [15:0]               ir;
    logic                      next_two;
    logic [7:0]                res;
    logic [`FLG_WIDTH-1:0]     flg_new;
    logic [7:0]                working_accumulator;
    logic [7:0]                bank_pointer;
    logic [`FLG_WIDTH-1:0]     flags;
    logic                      ext_en;
    logic [`DMEM_AW-1:0]       maddr;
    logic                      mrd;
    logic                      mwr;
    logic [7:0]                mwdata;
    logic                      done;
    logic                      skip;
    logic                      pready;
    logic [31:0]               prdata;
    logic                      pslverr;
    logic                      busy;
  } core_state_t;
endpackage

// file: sim/dmem_model.sv
// Data memory answering the core's read and write strobes
module dmem_model (
  input  wire logic        clk_i,
  input  wire logic [13:0] addr_i,
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:16383];
  initial foreach (mem[i]) mem[i] = 8'h00;
  // Outside a read the bus shows the inverse, so stale data never matches
  assign rdata_o = rd_i ? mem[addr_i] : ~mem[addr_i];
  always @(posedge clk_i) if (wr_i) mem[addr_i] <= wdata_i;
endmodule

// file: sim/incr_exec_monitor.sv
// Port checks of the increment core
`include "incr_defs.svh"
module incr_exec_monitor #(
  parameter int unsigned DMEM_AW = 14
) (
  input wire logic               clk_i,
  input wire logic               rst_n_i,
  input wire logic               ce_i,
  input wire logic               instr_valid_i,
  input wire logic [15:0]        instr_word_i,
  input wire logic               busy_o,
  input wire logic               done_o,
  input wire logic               skip_o,
  input wire logic [DMEM_AW-1:0] dmem_addr_o,
  input wire logic               dmem_rd_o,
  input wire logic [7:0]         dmem_rdata_i,
  input wire logic               dmem_wr_o,
  input wire logic [7:0]         dmem_wdata_o,
  input wire logic               psel_i,
  input wire logic               penable_i,
  input wire logic [DMEM_AW-1:0] paddr_i,
  input wire logic               pready_o,
  input wire logic               pslverr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] busy_len_q;
  logic       take;
  logic       plain;
  logic       mapped;
  assign take = ce_i && instr_valid_i && !busy_o;
  assign plain = take && instr_word_i[15:10] == `OPC_ADD_ONE;
  assign mapped = paddr_i inside {`REG_ARITH_FLAGS, `REG_BANK_POINTER,
    `REG_WORKING_ACC, `REG_CORE_CTRL, `REG_CORE_STATE};
  // Length of the busy run, judged at the done pulse
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) busy_len_q <= 4'h0;
    else busy_len_q <= busy_o ? busy_len_q + 4'h1 : 4'h0;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_front;
    busy_o ##1 dmem_rd_o;
  endsequence
  a_decode_then_read: assert property (plain |=> s_front)
    else $error("read phase not after decode");
  a_plain_done: assert property (plain |-> ##5 done_o && !skip_o)
    else $error("plain increment not done in four phases");
  a_write_sum: assert property (dmem_wr_o |-> $past(dmem_rd_o, 2) &&
    dmem_wdata_o == $past(dmem_rdata_i, 2) + 8'h01)
    else $error("written value is not operand plus one");
  a_write_addr: assert property (dmem_wr_o |->
    dmem_addr_o == $past(dmem_addr_o, 2))
    else $error("write address differs from read address");
  a_done_pulse: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  a_noskip_len: assert property (done_o && !skip_o |->
    busy_len_q == 4'h4)
    else $error("unskipped instruction not one cycle");
  a_skip_len: assert property (done_o && skip_o |->
    busy_len_q == 4'h8 || busy_len_q == 4'hC)
    else $error("skipped instruction not two or three cycles");
  a_apb_ready: assert property (psel_i && !penable_i |=>
    pready_o ##1 !pready_o)
    else $error("bus answer not one cycle after setup");
  a_unmapped_err: assert property (psel_i && !penable_i && !mapped |=>
    pslverr_o)
    else $error("unmapped access not refused");
endmodule
bind incr_exec incr_exec_monitor #(.DMEM_AW(DMEM_AW)) mon_inst (.clk_i,
  .rst_n_i, .ce_i, .instr_valid_i, .instr_word_i, .busy_o, .done_o, .skip_o,
  .dmem_addr_o, .dmem_rd_o, .dmem_rdata_i, .dmem_wr_o, .dmem_wdata_o,
  .psel_i, .penable_i, .paddr_i, .pready_o, .pslverr_o);

// file: sim/tb_increment_file_instructions.sv
// Self-checking bench of the increment core
`include "incr_defs.svh"
module tb_increment_file_instructions;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 0, rst_n_i = 0, instr_valid_i = 0;
  logic        next_two_word_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [15:0] instr_word_i = 16'h0000;
  logic [13:0] index_base_i = 14'h0000, paddr_i = 14'h0000, dmem_addr_o;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic        busy_o, done_o, skip_o, dmem_rd_o, dmem_wr_o, err;
  logic        pready_o, pslverr_o, ce_i = 1'b1;
  logic [7:0]  dmem_rdata_i, dmem_wdata_o;
  int          miscompares = 0, n_compared = 0, cyc;
  incr_exec incr_exec_inst (.clk_i, .rst_n_i, .ce_i, .instr_valid_i,
    .instr_word_i, .next_two_word_i, .busy_o, .done_o, .skip_o,
    .index_base_i, .dmem_addr_o, .dmem_rd_o, .dmem_rdata_i, .dmem_wr_o,
    .dmem_wdata_o, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pready_o, .prdata_o, .pslverr_o);
  dmem_model dmem_model_inst (.clk_i, .addr_i(dmem_addr_o), .rd_i(dmem_rd_o),
    .wr_i(dmem_wr_o), .wdata_i(dmem_wdata_o), .rdata_o(dmem_rdata_i));
  initial forever #10 clk_i = ~clk_i;
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(logic w, logic [13:0] a, logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Hold the request until ready is seen; only the watchdog ends a hang
    do @(posedge clk_i);
    while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wait_done();
    cyc = 0;
    do begin
      @(posedge clk_i);
      cyc++;
    end while (done_o !== 1'b1);
  endtask
  task automatic run(logic [15:0] w, logic two);
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_word_i <= w;
    next_two_word_i <= two;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    wait_done();
  endtask
  task automatic s_regs();
    apb(1'b0, `REG_ARITH_FLAGS, 32'h0);
    chk("flags", 32'h0, rd);
    apb(1'b0, `REG_BANK_POINTER, 32'h0);
    chk("bank", 32'h0, rd);
    apb(1'b0, `REG_WORKING_ACC, 32'h0);
    chk("acc", 32'h0, rd);
    apb(1'b0, 14'h0100, 32'h0);
    chk("unmapped err", 32'h1, err);
    chk("unmapped data", 32'h0, rd);
  endtask
  task automatic s_plain();
    dmem_model_inst.mem[14'h0010] = 8'hFF;
    run({`OPC_ADD_ONE, 2'b10, 8'h10}, 1'b0);
    chk("cycles", 32'h5, cyc);
    chk("wrap", 32'h0, dmem_model_inst.mem[14'h0010]);
    apb(1'b0, `REG_ARITH_FLAGS, 32'h0);
    chk("flags", 32'h07, rd);
  endtask
  // Clock enable low: the offered instruction must wait, nothing moves
  task automatic s_freeze();
    dmem_model_inst.mem[14'h0011] = 8'h41;
    @(posedge clk_i);
    ce_i <= 1'b0;
    instr_valid_i <= 1'b1;
    instr_word_i <= {`OPC_ADD_ONE, 2'b10, 8'h11};
    next_two_word_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("frozen busy", 32'h0, busy_o);
    ce_i <= 1'b1;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    wait_done();
    chk("frozen cycles", 32'h5, cyc);
    chk("frozen sum", 32'h42, dmem_model_inst.mem[14'h0011]);
  endtask
  task automatic s_dest0();
    apb(1'b1, `REG_BANK_POINTER, 32'h02);
    dmem_model_inst.mem[14'h0230] = 8'h7F;
    run({`OPC_ADD_ONE, 2'b01, 8'h30}, 1'b0);
    chk("reg kept", 32'h7F, dmem_model_inst.mem[14'h0230]);
    apb(1'b0, `REG_WORKING_ACC, 32'h0);
    chk("acc", 32'h80, rd);
    apb(1'b0, `REG_ARITH_FLAGS, 32'h0);
    chk("flags", 32'h1A, rd);
  endtask
  task automatic s_skip();
    apb(1'b1, `REG_ARITH_FLAGS, 32'h15);
    dmem_model_inst.mem[14'h3F80] = 8'hFF;
    run({`OPC_ADD_ONE_SKIP, 2'b10, 8'h80}, 1'b0);
    chk("cyc", 32'h9, cyc);
    chk("skip", 32'h1, skip_o);
    apb(1'b0, `REG_CORE_STATE, 32'h0);
    chk("state", 32'h40, rd);
    dmem_model_inst.mem[14'h3F80] = 8'hFF;
    run({`OPC_ADD_ONE_SKIP, 2'b10, 8'h80}, 1'b1);
    chk("cyc", 32'hD, cyc);
    run({`OPC_ADD_ONE_SKIP, 2'b10, 8'h80}, 1'b1);
    chk("cyc", 32'h5, cyc);
    chk("mem", 32'h1, dmem_model_inst.mem[14'h3F80]);
    apb(1'b0, `REG_ARITH_FLAGS, 32'h0);
    chk("flags", 32'h15, rd);
  endtask
  task automatic s_indexed();
    apb(1'b1, `REG_CORE_CTRL, 32'h01);
    apb(1'b0, `REG_CORE_CTRL, 32'h0);
    chk("ctrl", 32'h1, rd);
    index_base_i <= 14'h0100;
    dmem_model_inst.mem[14'h0120] = 8'h05;
    dmem_model_inst.mem[14'h3F60] = 8'h05;
    run({`OPC_ADD_ONE, 2'b10, 8'h20}, 1'b0);
    chk("indexed", 32'h6, dmem_model_inst.mem[14'h0120]);
    run({`OPC_ADD_ONE, 2'b10, 8'h60}, 1'b0);
    chk("above limit", 32'h6, dmem_model_inst.mem[14'h3F60]);
  endtask
  task automatic finish_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_i);
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1;
    repeat (4) @(posedge clk_i);
    s_regs();
    s_plain();
    s_freeze();
    s_dest0();
    s_skip();
    s_indexed();
    finish_test();
  end
endmodule
